// >>> verilog/rt_shared_ram_map.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - Shared RAM is word addressed and a host byte offset is twice the word.
// R2 - Area A stack pointer is read from word 0100h and area B from 0104h.
// R3 - Area A global ring pointer sits at word 0101 and area B at 0105.
// R4 - Mode code interrupt table is 0108-010F and mode data is 0110-013F; the code only addresses mode data at 0110-012F.
// R5 - Lookup groups of 32 run receive, transmit, broadcast, control words.
// R6 - With illegalization on, table 0300-03FF decides command legality.
// R7 - Busy bits per subaddress are read from words 0240-0247.
// R8 - Busy response in the status word is set per subaddress.
// R9 - Configuration 3 bits 14:13 pick a stack of 256, 512, 1024, 2048 words.
// R10 - Host may place the stack and data blocks anywhere not fixed.
// R11 - Response time is selectable between 2 and 5 microseconds.
// R12 - Words, format and RT-to-RT error conditions are checked.
// R13 - Single, per-subaddress ring and global ring buffering are offered.
// R14 - Status queue entries are filtered on valid, invalid or both.
// R15 - Control word picks single, double (receive only) or 128-8192 ring.
// R16 - Every location is sixteen bits and the host moves whole words.
module rt_shared_ram_map #(
    parameter int MEM_WORDS = 4096
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [12:0] host_memory_window_addr_in,
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic [15:0] host_wdata_in,
    output logic [15:0] host_rdata_out,
    output logic host_ack_out,
    input wire logic [15:0] config3_in,
    input wire logic illegal_enable_in,
    input wire logic resp_slow_in,
    input wire logic lookup_req_in,
    input wire rt_map_pkg::lookup_req_t lookup_in,
    output logic lookup_busy_out,
    output logic lookup_valid_out,
    output rt_map_pkg::lookup_rsp_t lookup_out,
    output logic [11:0] stack_words_out,
    output logic status_busy_out,
    output logic response_due_out,
    input wire logic msg_done_in,
    input wire rt_map_pkg::msg_check_t msg_check_in,
    input wire logic queue_valid_en_in,
    input wire logic queue_invalid_en_in,
    output logic msg_error_out,
    output logic queue_push_out
);
    localparam int AW = $clog2(MEM_WORDS);

    if (MEM_WORDS < 2048 || MEM_WORDS > 4096 ||
        (1 << AW) != MEM_WORDS) begin : g_bad_size
        $error("MEM_WORDS must be a power of two from 2048 to 4096.");
    end

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_STACK = 3'b001,
        ST_RING = 3'b010,
        ST_LUT = 3'b011,
        ST_CTRL = 3'b100,
        ST_BUSY = 3'b101,
        ST_ILLEG = 3'b110,
        ST_DONE = 3'b111
    } step_t;

    typedef struct packed {
        step_t step;
        step_t issued;
        logic granted;
        rt_map_pkg::lookup_req_t req;
        rt_map_pkg::lookup_rsp_t rsp;
        logic rsp_valid;
        logic host_ack;
        logic [15:0] host_rdata;
        logic resp_run;
        logic [7:0] resp_cnt;
        logic resp_due;
        logic msg_error;
        logic queue_push;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [15:0] mem [MEM_WORDS];
    logic [15:0] mem_rd_q;
    logic host_act;
    logic grant;
    logic [AW-1:0] mem_addr;
    logic [15:0] eng_addr;
    logic [15:0] bit_sel;
    logic [15:0] wc_sel;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    function automatic logic [15:0] lut_base(input logic area_b);
        lut_base = area_b ? rt_map_pkg::LUT_B_BASE :
            rt_map_pkg::LUT_A_BASE; // [R5]
    endfunction : lut_base

    function automatic logic [15:0] step_addr(
        input step_t st,
        input rt_map_pkg::lookup_req_t r
    );
        logic [15:0] grp;
        grp = 16'h0000;
        if (r.transmit) begin
            grp = rt_map_pkg::LUT_GROUP;
        end else if (r.broadcast && r.separate_bcast) begin
            grp = {rt_map_pkg::LUT_GROUP[14:0], 1'b0};
        end
        case (st)
            ST_STACK: step_addr = r.area_b ? rt_map_pkg::STACK_PTR_B :
                rt_map_pkg::STACK_PTR_A; // [R2]
            ST_RING: step_addr = r.area_b ? rt_map_pkg::RING_PTR_B :
                rt_map_pkg::RING_PTR_A; // [R3]
            ST_LUT: step_addr = lut_base(r.area_b) + grp +
                {11'h000, r.subaddress_index}; // [R5]
            ST_CTRL: step_addr = r.mode_code ?
                rt_map_pkg::MC_IRQ_BASE + {13'h0000, r.broadcast,
                r.transmit, r.count_or_code[4]} : // [R4]
                lut_base(r.area_b) + rt_map_pkg::CTRL_OFS +
                {11'h000, r.subaddress_index}; // [R5]
            ST_BUSY: step_addr = rt_map_pkg::BUSY_BASE + {13'h0000,
                r.broadcast, r.transmit, r.subaddress_index[4]}; // [R7]
            ST_ILLEG: step_addr = rt_map_pkg::ILLEG_BASE + {8'h00,
                r.broadcast, r.transmit, r.subaddress_index,
                r.count_or_code[4]}; // [R6]
            default: step_addr = 16'h0000;
        endcase
    endfunction : step_addr

    // ------------------------------------------------------------
    // Shared RAM, host first
    // ------------------------------------------------------------
    // The host always wins the single port; a lookup simply waits, so a
    // host hammering the window can delay the terminal's answer.
    assign host_act = host_rd_in || host_wr_in;
    assign grant = !host_act && s_q.step != ST_IDLE &&
        s_q.step != ST_DONE;
    assign eng_addr = step_addr(s_q.step, s_q.req);
    assign mem_addr = host_act ?
        host_memory_window_addr_in[AW:1] : eng_addr[AW-1:0]; // [R1]

    always_ff @(posedge clock_in) begin
        if (host_wr_in) begin
            mem[host_memory_window_addr_in[AW:1]] <= host_wdata_in; // [R16]
        end
        mem_rd_q <= mem[mem_addr];
    end

    // Busy bits are indexed by subaddress, while mode interrupt and illegal
    // bits use the low four bits of the count, so eight interrupt words
    // cover every mode code without spilling into the mode data area.
    assign bit_sel = 16'h0001 << s_q.req.subaddress_index[3:0];
    assign wc_sel = 16'h0001 << s_q.req.count_or_code[3:0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.host_ack = host_act;
        s_d.rsp_valid = 1'b0;
        s_d.resp_due = 1'b0;
        s_d.queue_push = 1'b0;
        s_d.granted = grant;
        if (s_q.host_ack) begin
            s_d.host_rdata = mem_rd_q;
        end
        if (grant) begin
            s_d.issued = s_q.step;
            s_d.step = step_t'(s_q.step + 3'd1);
        end
        if (s_q.granted) begin
            case (s_q.issued)
                ST_STACK: s_d.rsp.stack_ptr = mem_rd_q; // [R2]
                ST_RING: s_d.rsp.ring_ptr = mem_rd_q; // [R3]
                ST_LUT: s_d.rsp.data_ptr = mem_rd_q; // [R5]
                ST_CTRL: begin
                    s_d.rsp.subaddress_control_word = mem_rd_q;
                    s_d.rsp.mc_irq = s_q.req.mode_code &&
                        (mem_rd_q & wc_sel) != 16'h0000; // [R4]
                end
                ST_BUSY: s_d.rsp.busy =
                    (mem_rd_q & bit_sel) != 16'h0000; // [R8]
                ST_ILLEG: s_d.rsp.illegal = illegal_enable_in &&
                    (mem_rd_q & wc_sel) != 16'h0000; // [R6]
                default: s_d.rsp.busy = s_q.rsp.busy;
            endcase
        end
        case (s_q.step)
            ST_IDLE: begin
                if (lookup_req_in) begin
                    s_d.req = lookup_in;
                    s_d.step = ST_STACK;
                end
            end
            ST_DONE: begin
                if (!s_q.granted) begin
                    s_d.step = ST_IDLE;
                    s_d.rsp_valid = 1'b1;
                    s_d.resp_run = 1'b1;
                    s_d.resp_cnt = 8'h00;
                end
            end
            default: s_d.step = s_d.step;
        endcase
        // Control word decode; transmit never double buffers.
        s_d.rsp.scheme = rt_map_pkg::SCHEME_SINGLE; // [R13]
        s_d.rsp.ring_words = rt_map_pkg::RING_MIN_WORDS <<
            s_d.rsp.subaddress_control_word[2:0]; // [R15]
        if (s_d.rsp.subaddress_control_word[2:0] != 3'h0) begin
            s_d.rsp.scheme = rt_map_pkg::SCHEME_RING; // [R15]
        end else if (s_d.rsp.subaddress_control_word
            [rt_map_pkg::CTRL_DB_BIT] && !s_q.req.transmit) begin
            s_d.rsp.scheme = rt_map_pkg::SCHEME_DOUBLE; // [R15]
        end
        if (s_d.rsp.subaddress_control_word[rt_map_pkg::CTRL_DB_BIT] &&
            s_d.rsp.subaddress_control_word[2:0] != 3'h0 &&
            !s_q.req.transmit) begin
            s_d.rsp.scheme = rt_map_pkg::SCHEME_GLOBAL; // [R13]
        end
        s_d.rsp.mc_data_addr = rt_map_pkg::MC_DATA_BASE + {11'h000,
            s_q.req.transmit, s_q.req.count_or_code[3:0]}; // [R4]
        // Response timer counts from the end of the lookup.
        if (s_q.resp_run) begin
            s_d.resp_cnt = s_q.resp_cnt + 8'h01;
            if (s_q.resp_cnt == (resp_slow_in ? 8'(rt_map_pkg::RESP_SLOW_CYC)
                : 8'(rt_map_pkg::RESP_FAST_CYC)) - 8'h01) begin
                s_d.resp_run = 1'b0;
                s_d.resp_due = 1'b1; // [R11]
            end
        end
        if (msg_done_in) begin
            s_d.msg_error = |msg_check_in; // [R12]
            s_d.queue_push = (|msg_check_in) ? queue_invalid_en_in :
                queue_valid_en_in; // [R14]
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign host_rdata_out = s_q.host_rdata;
    assign host_ack_out = s_q.host_ack;
    assign lookup_busy_out = s_q.step != ST_IDLE;
    assign lookup_valid_out = s_q.rsp_valid;
    assign lookup_out = s_q.rsp;
    assign stack_words_out = rt_map_pkg::STACK_MIN_WORDS <<
        config3_in[rt_map_pkg::CFG3_STACK_LSB +: 2]; // [R9]
    assign status_busy_out = s_q.rsp.busy; // [R8]
    assign response_due_out = s_q.resp_due;
    assign msg_error_out = s_q.msg_error;
    assign queue_push_out = s_q.queue_push;
endmodule : rt_shared_ram_map

// >>> inc/rt_map_pkg.sv
package rt_map_pkg;
    // ------------------------------------------------------------
    // Fixed shared RAM locations (word addresses)
    // ------------------------------------------------------------
    localparam logic [15:0] STACK_PTR_A = 16'h0100;
    localparam logic [15:0] RING_PTR_A = 16'h0101;
    localparam logic [15:0] STACK_PTR_B = 16'h0104;
    localparam logic [15:0] RING_PTR_B = 16'h0105;
    localparam logic [15:0] MC_IRQ_BASE = 16'h0108;
    localparam logic [15:0] MC_DATA_BASE = 16'h0110;
    localparam logic [15:0] LUT_A_BASE = 16'h0140;
    localparam logic [15:0] LUT_B_BASE = 16'h01C0;
    localparam logic [15:0] LUT_GROUP = 16'h0020;
    localparam logic [15:0] CTRL_OFS = 16'h0060;
    localparam logic [15:0] BUSY_BASE = 16'h0240;
    localparam logic [15:0] ILLEG_BASE = 16'h0300;
    // ------------------------------------------------------------
    // Field layouts and sizes
    // ------------------------------------------------------------
    localparam int CFG3_STACK_LSB = 13;
    localparam int CTRL_DB_BIT = 15;
    localparam logic [11:0] STACK_MIN_WORDS = 12'h0100;
    localparam logic [13:0] RING_MIN_WORDS = 14'h0040;
    localparam logic [1:0] SCHEME_SINGLE = 2'h0;
    localparam logic [1:0] SCHEME_DOUBLE = 2'h1;
    localparam logic [1:0] SCHEME_RING = 2'h2;
    localparam logic [1:0] SCHEME_GLOBAL = 2'h3;
    // ------------------------------------------------------------
    // Response time
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESP_FAST_NS = 2000;
    localparam int RESP_SLOW_NS = 5000;
    localparam int RESP_FAST_CYC = (RESP_FAST_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int RESP_SLOW_CYC = RESP_SLOW_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic area_b;
        logic transmit;
        logic broadcast;
        logic separate_bcast;
        logic mode_code;
        logic [4:0] subaddress_index;
        logic [4:0] count_or_code;
    } lookup_req_t;

    typedef struct packed {
        logic [15:0] stack_ptr;
        logic [15:0] ring_ptr;
        logic [15:0] data_ptr;
        logic [15:0] subaddress_control_word;
        logic [1:0] scheme;
        logic [13:0] ring_words;
        logic [15:0] mc_data_addr;
        logic busy;
        logic illegal;
        logic mc_irq;
    } lookup_rsp_t;

    typedef struct packed {
        logic word_error;
        logic format_error;
        logic rt_rt_no_status;
        logic rt_rt_addr_mismatch;
        logic rt_rt_timeout;
    } msg_check_t;
endpackage : rt_map_pkg

// >>> dv/rt_map_properties.sv
`timescale 1ns/1ps
module rt_map_properties (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic host_rd_in,
    input wire logic host_wr_in,
    input wire logic host_ack_out,
    input wire logic [15:0] config3_in,
    input wire logic resp_slow_in,
    input wire logic lookup_req_in,
    input wire logic lookup_busy_out,
    input wire logic lookup_valid_out,
    input wire rt_map_pkg::lookup_rsp_t lookup_out,
    input wire logic [11:0] stack_words_out,
    input wire logic status_busy_out,
    input wire logic response_due_out,
    input wire logic msg_done_in,
    input wire rt_map_pkg::msg_check_t msg_check_in,
    input wire logic queue_valid_en_in,
    input wire logic queue_invalid_en_in,
    input wire logic msg_error_out,
    input wire logic queue_push_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_take;
        lookup_req_in && !lookup_busy_out;
    endsequence
    a_host_ack: assert property (
        (host_rd_in || host_wr_in) |=> host_ack_out)
        else $error("no acknowledge after host access");
    a_stack_size: assert property (
        stack_words_out == (rt_map_pkg::STACK_MIN_WORDS << config3_in[14:13]))
        else $error("stack size does not follow configuration");
    a_lookup_time: assert property (
        s_take |-> ##1 (!lookup_valid_out)[*7] ##[1:300] lookup_valid_out)
        else $error("lookup result early or missing");
    a_busy_hold: assert property (
        s_take |=> lookup_busy_out[*7])
        else $error("lookup busy dropped early");
    a_resp_fast: assert property (
        lookup_valid_out && !resp_slow_in |-> ##50 response_due_out)
        else $error("short response time wrong");
    a_resp_slow: assert property (
        lookup_valid_out && resp_slow_in |-> ##125 response_due_out)
        else $error("long response time wrong");
    a_status_busy: assert property (
        lookup_valid_out |=> status_busy_out == lookup_out.busy)
        else $error("status busy differs from lookup");
    a_busy_change: assert property (
        $changed(status_busy_out) |-> lookup_busy_out)
        else $error("status busy changed outside a lookup");
    a_msg_error: assert property (
        msg_done_in |=> msg_error_out == (|$past(msg_check_in)))
        else $error("message error flag wrong");
    a_queue_push: assert property (
        msg_done_in |=> queue_push_out == ((|$past(msg_check_in)) ?
        $past(queue_invalid_en_in) : $past(queue_valid_en_in)))
        else $error("queue filter wrong");
endmodule : rt_map_properties

bind rt_shared_ram_map rt_map_properties chk_u (
    .clock_in, .rst_n_in, .host_rd_in, .host_wr_in, .host_ack_out,
    .config3_in, .resp_slow_in, .lookup_req_in, .lookup_busy_out,
    .lookup_valid_out, .lookup_out, .stack_words_out, .status_busy_out,
    .response_due_out, .msg_done_in, .msg_check_in, .queue_valid_en_in,
    .queue_invalid_en_in, .msg_error_out, .queue_push_out);

// >>> dv/host_model.sv
`timescale 1ns/1ps
module host_model (
    input wire logic clock_in,
    input wire logic ack_in,
    input wire logic [15:0] rdata_in,
    output logic [12:0] addr_out,
    output logic rd_out,
    output logic wr_out,
    output logic [15:0] wdata_out
);
    initial begin
        addr_out = '0;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = '0;
    end
    // The strobe lasts one cycle because a longer one is a second access.
    task automatic xfer(input logic w, input logic [12:0] a,
        input logic [15:0] d, output logic [15:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge clock_in);
        addr_out <= a;
        wdata_out <= d;
        rd_out <= !w;
        wr_out <= w;
        @(posedge clock_in);
        rd_out <= 1'b0;
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
        do begin
            @(posedge clock_in);
            n++;
        end while (!ack_in && n < 4);
        ok = ack_in;
        @(posedge clock_in);
        q = rdata_in;
    endtask : xfer
endmodule : host_model

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic clock_in = 1'b0, rst_n_in = 1'b0;
    logic [12:0] host_memory_window_addr_in;
    logic host_rd_in, host_wr_in, host_ack_out;
    logic [15:0] host_wdata_in, host_rdata_out, config3_in = '0;
    logic illegal_enable_in = 1'b0, resp_slow_in = 1'b0;
    logic lookup_req_in = 1'b0, msg_done_in = 1'b0;
    logic queue_valid_en_in = 1'b0, queue_invalid_en_in = 1'b0;
    logic lookup_busy_out, lookup_valid_out, status_busy_out;
    logic response_due_out, msg_error_out, queue_push_out;
    logic [11:0] stack_words_out;
    rt_map_pkg::lookup_req_t lookup_in = '0;
    rt_map_pkg::lookup_rsp_t lookup_out;
    rt_map_pkg::msg_check_t msg_check_in = '0;
    int miscompares = 0, n_checks = 0;
    logic [11:0] wa [14] = '{12'h100, 12'h101, 12'h104, 12'h105, 12'h143,
        12'h1A3, 12'h240, 12'h306, 12'h1F1, 12'h231, 12'h10B, 12'h243,
        12'h242, 12'h222};
    logic [15:0] wd [14] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444,
        16'h0A00, 16'h8000, 16'h0008, 16'h0020, 16'h0B00, 16'h0003, 16'h0004,
        16'hFFFD, 16'hFFFE, 16'h8001};
    always #20 clock_in = ~clock_in;
    rt_shared_ram_map dut_u (.clock_in, .rst_n_in, .host_memory_window_addr_in,
        .host_rd_in, .host_wr_in, .host_wdata_in, .host_rdata_out,
        .host_ack_out, .config3_in, .illegal_enable_in, .resp_slow_in,
        .lookup_req_in, .lookup_in, .lookup_busy_out, .lookup_valid_out,
        .lookup_out, .stack_words_out, .status_busy_out, .response_due_out,
        .msg_done_in, .msg_check_in, .queue_valid_en_in,
        .queue_invalid_en_in, .msg_error_out, .queue_push_out);
    host_model host_u (.clock_in, .ack_in(host_ack_out),
        .rdata_in(host_rdata_out), .addr_out(host_memory_window_addr_in),
        .rd_out(host_rd_in), .wr_out(host_wr_in), .wdata_out(host_wdata_in));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    task automatic hang;
        miscompares++;
        end_sim();
    endtask : hang
    task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic xfer(logic w, logic [12:0] a, logic [15:0] d);
        logic [15:0] q;
        logic ok;
        host_u.xfer(w, a, d, q, ok);
        if (!ok)
            hang();
        if (!w)
            cmp("read word", d, q);
    endtask : xfer
    task automatic lk(rt_map_pkg::lookup_req_t q);
        int n;
        n = 0;
        @(posedge clock_in);
        lookup_in <= q;
        lookup_req_in <= 1'b1;
        @(posedge clock_in);
        lookup_req_in <= 1'b0;
        while (!lookup_valid_out && n < 40) begin
            @(posedge clock_in);
            n++;
        end
        if (!lookup_valid_out)
            hang();
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (!response_due_out && n < 200);
        cmp("response delay", resp_slow_in ? 16'(rt_map_pkg::RESP_SLOW_CYC) :
            16'(rt_map_pkg::RESP_FAST_CYC), 16'(n));
    endtask : lk
    task automatic t_window;
        foreach (wa[i])
            xfer(1'b1, {wa[i], 1'b0}, wd[i]);
        xfer(1'b0, 13'h0203, 16'h2222);
        xfer(1'b0, 13'h0208, 16'h3333);
        $display("test window done");
    endtask : t_window
    task automatic t_area_a;
        illegal_enable_in <= 1'b1;
        lk({5'b00000, 5'd3, 5'd5});
        cmp("stack a", 16'h1111, lookup_out.stack_ptr);
        cmp("ring a", 16'h2222, lookup_out.ring_ptr);
        cmp("data a", 16'h0A00, lookup_out.data_ptr);
        cmp("control a", 16'h8000, lookup_out.subaddress_control_word);
        cmp("scheme a", rt_map_pkg::SCHEME_DOUBLE, lookup_out.scheme);
        cmp("busy a", 16'h1, lookup_out.busy);
        cmp("status busy a", 16'h1, status_busy_out);
        cmp("illegal a", 16'h1, lookup_out.illegal);
        $display("test area a done");
    endtask : t_area_a
    task automatic t_area_b;
        illegal_enable_in <= 1'b0;
        resp_slow_in <= 1'b1;
        lk({5'b11000, 5'd17, 5'd0});
        cmp("stack b", 16'h3333, lookup_out.stack_ptr);
        cmp("ring b", 16'h4444, lookup_out.ring_ptr);
        cmp("data b", 16'h0B00, lookup_out.data_ptr);
        cmp("control b", 16'h0003, lookup_out.subaddress_control_word);
        cmp("scheme b", rt_map_pkg::SCHEME_RING, lookup_out.scheme);
        cmp("ring size", rt_map_pkg::RING_MIN_WORDS << 3,
            lookup_out.ring_words);
        cmp("status busy b", 16'h0, status_busy_out);
        cmp("illegal off", 16'h0, lookup_out.illegal);
        resp_slow_in <= 1'b0;
        lk({5'b01001, 5'd0, 5'd18});
        cmp("mode data", 16'h0122, lookup_out.mc_data_addr);
        cmp("mode irq", 16'h1, lookup_out.mc_irq);
        cmp("status busy mode", 16'h0, status_busy_out);
        lk({5'b10000, 5'd2, 5'd0});
        cmp("scheme global", rt_map_pkg::SCHEME_GLOBAL,
            lookup_out.scheme);
        cmp("global size", rt_map_pkg::RING_MIN_WORDS << 1,
            lookup_out.ring_words);
        cmp("status busy global", 16'h0, status_busy_out);
        $display("test area b and mode done");
    endtask : t_area_b
    task automatic t_stack;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_in);
            config3_in <= {1'b0, 2'(i), 13'h0000};
            @(posedge clock_in);
            cmp("stack words", rt_map_pkg::STACK_MIN_WORDS << i,
                stack_words_out);
        end
        $display("test stack size done");
    endtask : t_stack
    task automatic t_msg;
        for (int i = 0; i < 6; i++)
            for (int j = 0; j < 4; j++) begin
                @(posedge clock_in);
                msg_check_in <= (i != 0) ? 5'(1 << (i - 1)) : 5'h00;
                {queue_valid_en_in, queue_invalid_en_in} <= 2'(j);
                msg_done_in <= 1'b1;
                @(posedge clock_in);
                msg_done_in <= 1'b0;
                @(posedge clock_in);
                cmp("message error", 16'(i != 0), msg_error_out);
                cmp("queue push", i ? j[0] : j[1], queue_push_out);
            end
        $display("test message filter done");
    endtask : t_msg
    initial begin
        repeat (20) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        t_window();
        t_area_a();
        t_area_b();
        t_stack();
        t_msg();
        end_sim();
    end
endmodule : tb
